// ==== hdl/psr_cfg.svh ====
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
// Register offsets from the configuration I/O base
`define PSR_OFF_MODE_A 8'h02
`define PSR_OFF_MODE_B 8'h03
`define PSR_OFF_DIR_A 8'h04
`define PSR_OFF_DIR_B 8'h05
`define PSR_OFF_DIR_C 8'h14
`define PSR_OFF_DIR_D 8'h15
`define PSR_OFF_DRV_A 8'h06
`define PSR_OFF_DRV_B 8'h07
`define PSR_OFF_DRV_C 8'h16
`define PSR_OFF_DRV_D 8'h17
`define PSR_RESET_VAL 8'h00
`define PSR_PORTD_MASK 8'h07
// Drive-select meaning per bit: 1 = open-drain, 0 = slew
`define PSR_OD_MAP_A 8'hf0
`define PSR_OD_MAP_B 8'hf0
`define PSR_OD_MAP_C 8'hff
`define PSR_OD_MAP_D 8'h00
`endif

// ==== hdl/psr_pkg.sv ====
package psr_pkg;
    typedef logic [7:0] psr_byte_t;
    typedef enum logic [1:0] {
        PSR_PORT_A,
        PSR_PORT_B,
        PSR_PORT_C,
        PSR_PORT_D
    } psr_port_t;
endpackage

// ==== hdl/psr_port_setup.sv ====
`timescale 1ns/1ps
`include "psr_cfg.svh"
// Notes on behaviour
// R01: Host reads and writes registers at offsets.
// R02: Each bit controls only its own pin.
// R03: All registers clear to zero at reset.
// R04: Mode bit zero general I/O, one address-out.
// R05: Mode register exists only for A, B.
// R06: Direction one is output, zero is input.
// R07: Pins come up as inputs.
// R08: A-C driver enabled by term OR direction.
// R09: Inactive term leaves direction bit alone.
// R10: Port D direction has three working bits.
// R11: Drive bit one gives open-drain, else push-pull.
// R12: Drive bit one gives fast slew, else slow.
// R13: Each drive bit has one fixed meaning.
// R14: Host sets mode and direction for address-out. Code also drives address-out with mode and product term only.
// R15: Data driven only when enabled, else tri-stated.
// R16: Unimplemented bits ignore writes, read zero.
module psr_port_setup (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire psr_pkg::psr_byte_t bus_wdata,
    output psr_pkg::psr_byte_t bus_rdata,
    input wire psr_pkg::psr_byte_t pt_oe_a,
    input wire psr_pkg::psr_byte_t pt_oe_b,
    input wire psr_pkg::psr_byte_t pt_oe_c,
    output psr_pkg::psr_byte_t oe_a,
    output psr_pkg::psr_byte_t oe_b,
    output psr_pkg::psr_byte_t oe_c,
    output psr_pkg::psr_byte_t oe_d,
    output psr_pkg::psr_byte_t addr_out_a,
    output psr_pkg::psr_byte_t addr_out_b,
    output psr_pkg::psr_byte_t open_drain_a,
    output psr_pkg::psr_byte_t open_drain_b,
    output psr_pkg::psr_byte_t open_drain_c,
    output psr_pkg::psr_byte_t open_drain_d,
    output psr_pkg::psr_byte_t fast_slew_a,
    output psr_pkg::psr_byte_t fast_slew_b,
    output psr_pkg::psr_byte_t fast_slew_c,
    output psr_pkg::psr_byte_t fast_slew_d
);
    import psr_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Split one drive byte by its port's fixed per-pin meaning
    function automatic psr_byte_t od_part(input psr_byte_t drv, input psr_byte_t map);
        od_part = drv & map;
    endfunction

    function automatic psr_byte_t slew_part(input psr_byte_t drv, input psr_byte_t map);
        slew_part = drv & ~map;
    endfunction

    // Port D has three pins; its upper bits have no storage behind them
    function automatic psr_byte_t pins_d(input psr_byte_t v);
        pins_d = v & `PSR_PORTD_MASK;
    endfunction

    psr_byte_t mode_a_q, mode_b_q;
    psr_byte_t dir_a_q, dir_b_q, dir_c_q, dir_d_q;
    psr_byte_t drv_a_q, drv_b_q, drv_c_q, drv_d_q;
    psr_byte_t rdata_q;

    wire we = ce && bus_wr;
    wire rd_en = ce && bus_rd;
    wire hit_mode_a = we && (bus_addr == `PSR_OFF_MODE_A);
    wire hit_mode_b = we && (bus_addr == `PSR_OFF_MODE_B);
    wire hit_dir_a = we && (bus_addr == `PSR_OFF_DIR_A);
    wire hit_dir_b = we && (bus_addr == `PSR_OFF_DIR_B);
    wire hit_dir_c = we && (bus_addr == `PSR_OFF_DIR_C);
    wire hit_dir_d = we && (bus_addr == `PSR_OFF_DIR_D);
    wire hit_drv_a = we && (bus_addr == `PSR_OFF_DRV_A);
    wire hit_drv_b = we && (bus_addr == `PSR_OFF_DRV_B);
    wire hit_drv_c = we && (bus_addr == `PSR_OFF_DRV_C);
    wire hit_drv_d = we && (bus_addr == `PSR_OFF_DRV_D);

    // Read mux; unmapped offsets answer zero
    psr_byte_t rd_sel;
    always_comb begin
        case (bus_addr)
            `PSR_OFF_MODE_A: rd_sel = mode_a_q; // R01 R05
            `PSR_OFF_MODE_B: rd_sel = mode_b_q;
            `PSR_OFF_DIR_A: rd_sel = dir_a_q;
            `PSR_OFF_DIR_B: rd_sel = dir_b_q;
            `PSR_OFF_DIR_C: rd_sel = dir_c_q;
            `PSR_OFF_DIR_D: rd_sel = pins_d(dir_d_q); // R16
            `PSR_OFF_DRV_A: rd_sel = drv_a_q;
            `PSR_OFF_DRV_B: rd_sel = drv_b_q;
            `PSR_OFF_DRV_C: rd_sel = drv_c_q;
            `PSR_OFF_DRV_D: rd_sel = pins_d(drv_d_q); // R16
            default: rd_sel = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_a_q <= `PSR_RESET_VAL; // R03 R04
        end else if (hit_mode_a) begin
            mode_a_q <= bus_wdata; // R01
        end
    end

    mode_a_wr_a: assert property ( // R01
        hit_mode_a |=> mode_a_q == $past(bus_wdata))
        else $error("mode a write not stored");

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_b_q <= `PSR_RESET_VAL;
        end else if (hit_mode_b) begin
            mode_b_q <= bus_wdata;
        end
    end

    mode_b_wr_a: assert property ( // R01
        hit_mode_b |=> mode_b_q == $past(bus_wdata))
        else $error("mode b write not stored");

    always_ff @(posedge clk) begin
        if (srst) begin
            dir_a_q <= `PSR_RESET_VAL; // R03 R07
        end else if (hit_dir_a) begin
            dir_a_q <= bus_wdata;
        end
    end

    dir_a_keep_a: assert property ( // R16
        !hit_dir_a |=> $stable(dir_a_q))
        else $error("direction a moved without a write");

    always_ff @(posedge clk) begin
        if (srst) begin
            dir_b_q <= `PSR_RESET_VAL;
        end else if (hit_dir_b) begin
            dir_b_q <= bus_wdata;
        end
    end

    dir_b_keep_a: assert property ( // R16
        !hit_dir_b |=> $stable(dir_b_q))
        else $error("direction b moved without a write");

    always_ff @(posedge clk) begin
        if (srst) begin
            dir_c_q <= `PSR_RESET_VAL;
        end else if (hit_dir_c) begin
            dir_c_q <= bus_wdata;
        end
    end

    dir_c_keep_a: assert property ( // R16
        !hit_dir_c |=> $stable(dir_c_q))
        else $error("direction c moved without a write");

    always_ff @(posedge clk) begin
        if (srst) begin
            dir_d_q <= `PSR_RESET_VAL;
        end else if (hit_dir_d) begin
            dir_d_q <= pins_d(bus_wdata); // R10 R16
        end
    end

    dir_d_wr_a: assert property ( // R10
        hit_dir_d |=> dir_d_q == ($past(bus_wdata) & 8'h07))
        else $error("port d direction write wrong");

    always_ff @(posedge clk) begin
        if (srst) begin
            drv_a_q <= `PSR_RESET_VAL;
        end else if (hit_drv_a) begin
            drv_a_q <= bus_wdata;
        end
    end

    drv_a_wr_a: assert property ( // R01
        hit_drv_a |=> drv_a_q == $past(bus_wdata))
        else $error("drive a write not stored");

    always_ff @(posedge clk) begin
        if (srst) begin
            drv_b_q <= `PSR_RESET_VAL;
        end else if (hit_drv_b) begin
            drv_b_q <= bus_wdata;
        end
    end

    drv_b_wr_a: assert property ( // R01
        hit_drv_b |=> drv_b_q == $past(bus_wdata))
        else $error("drive b write not stored");

    always_ff @(posedge clk) begin
        if (srst) begin
            drv_c_q <= `PSR_RESET_VAL;
        end else if (hit_drv_c) begin
            drv_c_q <= bus_wdata;
        end
    end

    drv_c_wr_a: assert property ( // R01
        hit_drv_c |=> drv_c_q == $past(bus_wdata))
        else $error("drive c write not stored");

    always_ff @(posedge clk) begin
        if (srst) begin
            drv_d_q <= `PSR_RESET_VAL;
        end else if (hit_drv_d) begin
            drv_d_q <= pins_d(bus_wdata); // R16
        end
    end

    drv_d_top_a: assert property ( // R16
        (drv_d_q & 8'hf8) == 8'h00)
        else $error("port d drive upper bits stored");

    // Registered so read data stands steady until the next read
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= `PSR_RESET_VAL;
        end else if (rd_en) begin
            rdata_q <= rd_sel; // R01
        end
    end

    rdata_hold_a: assert property ( // R01
        !rd_en |=> $stable(bus_rdata))
        else $error("read data moved without a read");

    assign bus_rdata = rdata_q;

    // Bitwise ops keep every pin independent
    assign oe_a = dir_a_q | pt_oe_a; // R02 R06 R08 R09 R15
    assign oe_b = dir_b_q | pt_oe_b; // R08 R15
    assign oe_c = dir_c_q | pt_oe_c; // R08 R15
    // Port D has no product-term enable here
    assign oe_d = pins_d(dir_d_q); // R10 R06

    term_off_a: assert property ( // R09
        (pt_oe_a != 8'h00 || oe_a == dir_a_q) && (pt_oe_b != 8'h00 || oe_b == dir_b_q))
        else $error("direction bit not in sole control");

    // Address drive only when pin is also enabled, by direction or product term
    assign addr_out_a = mode_a_q & oe_a; // R04 R14
    assign addr_out_b = mode_b_q & oe_b; // R04 R14

    mode_zero_a: assert property ( // R04
        (addr_out_a & ~mode_a_q) == 8'h00 && (addr_out_b & ~mode_b_q) == 8'h00)
        else $error("address out while in general mode");

    assign open_drain_a = od_part(drv_a_q, `PSR_OD_MAP_A); // R11 R13
    assign open_drain_b = od_part(drv_b_q, `PSR_OD_MAP_B);
    assign open_drain_c = od_part(drv_c_q, `PSR_OD_MAP_C);
    assign open_drain_d = od_part(drv_d_q, `PSR_OD_MAP_D);
    assign fast_slew_a = slew_part(drv_a_q, `PSR_OD_MAP_A); // R12 R13
    assign fast_slew_b = slew_part(drv_b_q, `PSR_OD_MAP_B);
    assign fast_slew_c = slew_part(drv_c_q, `PSR_OD_MAP_C);
    assign fast_slew_d = pins_d(slew_part(drv_d_q, `PSR_OD_MAP_D));

    split_b_a: assert property ( // R13
        (open_drain_b & fast_slew_b) == 8'h00 && (open_drain_b | fast_slew_b) == drv_b_q)
        else $error("port b drive meaning overlap");

    fixed_cd_a: assert property ( // R13
        fast_slew_c == 8'h00 && open_drain_d == 8'h00)
        else $error("port c or d drive meaning wrong");

    slew_d_a: assert property ( // R12
        hit_drv_d |=> fast_slew_d == ($past(bus_wdata) & 8'h07))
        else $error("port d slew bits wrong");

    write_read_a: assert property ( // R01
        ce && hit_dir_a |=> dir_a_q == $past(bus_wdata))
        else $error("direction write not stored");
    read_data_a: assert property ( // R01
        ce && bus_rd && !bus_wr && bus_addr == `PSR_OFF_DIR_B |=> bus_rdata == dir_b_q)
        else $error("read data mismatch");
    reset_clear_a: assert property ( // R03
        $past(srst) |-> (oe_d == 8'h00 && open_drain_c == 8'h00 && mode_a_q == 8'h00))
        else $error("reset left state set");
    dir_or_a: assert property ( // R08
        oe_c == (dir_c_q | pt_oe_c))
        else $error("port c enable wrong");
    portd_mask_a: assert property ( // R10
        (oe_d & ~8'h07) == 8'h00 && (fast_slew_d & ~8'h07) == 8'h00)
        else $error("port d upper bits live");
    od_slew_split_a: assert property ( // R13
        (open_drain_a & fast_slew_a) == 8'h00 && (open_drain_a | fast_slew_a) == drv_a_q)
        else $error("drive meaning overlap");
    addr_gate_a: assert property ( // R14
        (addr_out_b & ~oe_b) == 8'h00)
        else $error("address out without enable");
    hold_ce_a: assert property ( // R01
        !ce |=> $stable(dir_a_q) && $stable(bus_rdata))
        else $error("state moved with ce low");
    unmapped_a: assert property ( // R16
        ce && bus_rd && bus_addr == 8'hff |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");

    cov_write_c: cover property (ce && hit_mode_a ##1 addr_out_a != 8'h00);
    cov_pt_c: cover property (pt_oe_a != 8'h00 && dir_a_q == 8'h00);
    cov_read_c: cover property (ce && bus_rd ##1 bus_rdata != 8'h00);
    cov_ce_c: cover property (!ce && bus_wr);
    cov_portd_c: cover property (hit_dir_d ##1 oe_d == 8'h07);
endmodule

// ==== test/psr_host.sv ====
`timescale 1ns/1ps
module psr_host (
    input wire logic clk,
    output logic [7:0] bus_addr,
    output logic bus_wr,
    output logic bus_rd,
    output psr_pkg::psr_byte_t bus_wdata,
    input wire psr_pkg::psr_byte_t bus_rdata
);
    import psr_pkg::*;
    initial begin
        bus_addr = 8'hff;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input psr_byte_t d);
        @(negedge clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
        // Stale data must not look valid
        bus_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output psr_byte_t d);
        @(negedge clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        d = bus_rdata;
    endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`include "psr_cfg.svh"
module tb_top;
    import psr_pkg::*;
    logic clk, srst, ce, bus_wr, bus_rd;
    logic [7:0] bus_addr;
    psr_byte_t bus_wdata, bus_rdata, pt_oe_a, pt_oe_b, pt_oe_c, oe_a, oe_b, oe_c, oe_d, v;
    psr_byte_t addr_out_a, addr_out_b, open_drain_a, open_drain_b, open_drain_c, open_drain_d;
    psr_byte_t fast_slew_a, fast_slew_b, fast_slew_c, fast_slew_d;
    int miscompares = 0;
    int n_compared = 0;
    psr_byte_t offs [10] = '{`PSR_OFF_MODE_A, `PSR_OFF_MODE_B, `PSR_OFF_DIR_A, `PSR_OFF_DIR_B,
        `PSR_OFF_DIR_C, `PSR_OFF_DIR_D, `PSR_OFF_DRV_A, `PSR_OFF_DRV_B, `PSR_OFF_DRV_C,
        `PSR_OFF_DRV_D};
    psr_port_setup u_psr_port_setup (.clk, .srst, .ce, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
        .bus_rdata, .pt_oe_a, .pt_oe_b, .pt_oe_c, .oe_a, .oe_b, .oe_c, .oe_d, .addr_out_a,
        .addr_out_b, .open_drain_a, .open_drain_b, .open_drain_c, .open_drain_d, .fast_slew_a,
        .fast_slew_b, .fast_slew_c, .fast_slew_d);
    psr_host u_psr_host (.clk, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata);
    task automatic chk(input psr_byte_t got, input psr_byte_t exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic t_reset;
        foreach (offs[i]) begin
            u_psr_host.rd(offs[i], v);
            chk(v, 8'h00);
        end
        chk(oe_a | oe_b | oe_c | oe_d, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_dir;
        pt_oe_a = 8'h3c;
        u_psr_host.wr(`PSR_OFF_DIR_A, 8'h0f);
        u_psr_host.wr(`PSR_OFF_DIR_C, 8'h01);
        u_psr_host.wr(`PSR_OFF_DIR_D, 8'hff);
        pt_oe_b = 8'h80;
        pt_oe_c = 8'h30;
        @(negedge clk);
        chk(oe_a, 8'h3f);
        chk(oe_b, 8'h80);
        chk(oe_c, 8'h31);
        chk(oe_d, 8'h07);
        pt_oe_a = 8'h00;
        pt_oe_c = 8'h00;
        @(negedge clk);
        chk(oe_a, 8'h0f);
        chk(oe_c, 8'h01);
        $display("t_dir done");
    endtask
    task automatic t_drive;
        u_psr_host.wr(`PSR_OFF_DRV_A, 8'hff);
        u_psr_host.wr(`PSR_OFF_DRV_B, 8'h5a);
        u_psr_host.wr(`PSR_OFF_DRV_C, 8'hff);
        u_psr_host.wr(`PSR_OFF_DRV_D, 8'hff);
        chk(open_drain_a, 8'hf0);
        chk(fast_slew_a, 8'h0f);
        chk(open_drain_b, 8'h50);
        chk(fast_slew_b, 8'h0a);
        chk(open_drain_c | fast_slew_c, 8'hff);
        chk(open_drain_c, 8'hff);
        chk(fast_slew_c, 8'h00);
        chk(open_drain_d, 8'h00);
        chk(fast_slew_d, 8'h07);
        $display("t_drive done");
    endtask
    task automatic t_mode;
        u_psr_host.wr(`PSR_OFF_MODE_A, 8'hff);
        u_psr_host.wr(`PSR_OFF_MODE_B, 8'h03);
        pt_oe_b = 8'h01;
        @(negedge clk);
        chk(addr_out_a, 8'h0f);
        chk(addr_out_b, 8'h01);
        u_psr_host.wr(`PSR_OFF_MODE_A, 8'h00);
        chk(addr_out_a, 8'h00);
        u_psr_host.rd(`PSR_OFF_MODE_B, v);
        chk(v, 8'h03);
        u_psr_host.wr(8'h12, 8'hff);
        u_psr_host.rd(8'h12, v);
        chk(v, 8'h00);
        $display("t_mode done");
    endtask
    task automatic t_ce;
        u_psr_host.rd(`PSR_OFF_DIR_C, v);
        chk(v, 8'h01);
        ce = 1'b0;
        u_psr_host.wr(`PSR_OFF_DIR_A, 8'h5a);
        u_psr_host.rd(`PSR_OFF_DIR_A, v);
        chk(v, 8'h01);
        ce = 1'b1;
        chk(oe_a, 8'h0f);
        u_psr_host.rd(`PSR_OFF_DIR_A, v);
        chk(v, 8'h0f);
        u_psr_host.rd(8'hff, v);
        chk(v, 8'h00);
        $display("t_ce done");
    endtask
    task automatic t_regs;
        foreach (offs[i]) u_psr_host.wr(offs[i], 8'hc3 ^ 8'(i));
        foreach (offs[i]) begin
            u_psr_host.rd(offs[i], v);
            chk(v, (i == 5 || i == 9) ? 8'h07 & (8'hc3 ^ 8'(i)) : 8'hc3 ^ 8'(i));
        end
        $display("t_regs done");
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        results();
    end
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        pt_oe_a = 8'h00;
        pt_oe_b = 8'h00;
        pt_oe_c = 8'h00;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_dir();
        t_drive();
        t_mode();
        t_ce();
        t_regs();
        pt_oe_b = 8'h00;
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        t_reset();
        results();
    end
endmodule
